// ==== src/edmp_pkg.sv ====
// Package: constants, register map and carrier types of the external data memory port
package edmp_pkg;

  // Special-function register addresses
  localparam logic [7:0] EDMP_CFG_ADDR = 8'hA3; // ext_memory_config
  localparam logic [7:0] EDMP_PAGE_ADDR = 8'hAF; // xram_page_select

  // Values after reset
  localparam logic [7:0] EDMP_CFG_RESET = 8'h03;
  localparam logic [7:0] EDMP_PAGE_RESET = 8'h00;

  // Field positions inside ext_memory_config
  localparam int EDMP_BANK_BIT = 5; // port_bank_select
  localparam int EDMP_MUX_BIT = 4; // mux_mode_select
  localparam int EDMP_MAP_LSB = 2; // memory_map_mode [3:2]
  localparam int EDMP_ALE_LSB = 0; // latch_pulse_width [1:0]
  localparam logic [7:0] EDMP_CFG_WMASK = 8'h3F; // Bits 7..6 not stored

  // Memory map mode encodings
  localparam logic [1:0] EDMP_MAP_INTERNAL = 2'h0;
  localparam logic [1:0] EDMP_MAP_SPLIT = 2'h1;
  localparam logic [1:0] EDMP_MAP_SPLIT_PAGE = 2'h2;
  localparam logic [1:0] EDMP_MAP_EXTERNAL = 2'h3;

  // On-chip space: 4k bytes, addressed by 12 bits
  localparam int EDMP_ONCHIP_AW = 12;
  localparam logic [15:0] EDMP_ONCHIP_TOP = 16'h1000;

  // Fixed overhead of an off-chip access, in system clock cycles
  localparam int EDMP_OVERHEAD_CYCLES = 4;
  localparam int EDMP_ADDR_CYCLES = 1;
  localparam int EDMP_TAIL_CYCLES = EDMP_OVERHEAD_CYCLES - EDMP_ADDR_CYCLES;
  localparam int EDMP_CNT_W = 5;

  // Decoded configuration register
  typedef struct packed {
    logic bank_hi; // 1: upper four ports carry the bus
    logic separate; // 1: separate address and data pins
    logic [1:0] map_mode; // memory_map_mode
    logic [1:0] ale_width; // latch_pulse_width code
  } edmp_cfg_s;

  // Strobe timing from the bus_timing_control register outside
  typedef struct packed {
    logic [1:0] setup; // Address setup cycles
    logic [3:0] width; // Strobe width code, width+1 cycles
    logic [1:0] hold; // Address hold cycles
  } edmp_timing_s;

  // One port bank worth of bus pins
  typedef struct packed {
    logic [7:0] addr_hi; // A[15:8]
    logic addr_hi_oe;
    logic [7:0] addr_lo; // A[7:0], separate mode only
    logic addr_lo_oe;
    logic [7:0] ad; // Data, or shared address/data
    logic ad_oe;
    logic ale; // Address latch strobe
    logic ale_oe;
    logic rd_n; // Read strobe, active low
    logic wr_n; // Write strobe, active low
    logic strobe_oe; // Enable of rd_n and wr_n
  } edmp_pins_s;

  // Bank pins when the interface does not own them
  localparam edmp_pins_s EDMP_PINS_IDLE = '{addr_hi: 8'h00, addr_hi_oe: 1'b0, addr_lo: 8'h00,
    addr_lo_oe: 1'b0, ad: 8'h00, ad_oe: 1'b0, ale: 1'b0, ale_oe: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
    strobe_oe: 1'b0};

endpackage

// ==== src/edmp_regs.sv ====
// Configuration and page select registers on the special-function register port
`timescale 1ns/10ps
`default_nettype none
module edmp_regs (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  output edmp_pkg::edmp_cfg_s cfg,
  output logic [7:0] page_high_byte
);
  import edmp_pkg::*;

  logic [7:0] cfg_r, cfg_nxt; // Stored configuration bits
  logic [7:0] page_r, page_nxt; // Page select
  logic [7:0] rdata_r, rdata_nxt; // Read data register
  logic hit_r, hit_nxt; // Read hit flag

  // Write decode and read mux
  always_comb begin
    cfg_nxt = cfg_r;
    page_nxt = page_r;
    rdata_nxt = rdata_r;
    hit_nxt = 1'b0;
    if (sfr_we && sfr_addr == EDMP_CFG_ADDR) begin
      cfg_nxt = sfr_wdata & EDMP_CFG_WMASK;
    end
    if (sfr_we && sfr_addr == EDMP_PAGE_ADDR) begin
      page_nxt = sfr_wdata;
    end
    if (sfr_re) begin
      case (sfr_addr)
        EDMP_CFG_ADDR: begin
          rdata_nxt = cfg_r & EDMP_CFG_WMASK;
          hit_nxt = 1'b1;
        end
        EDMP_PAGE_ADDR: begin
          rdata_nxt = page_r;
          hit_nxt = 1'b1;
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  // Register update
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cfg_r <= EDMP_CFG_RESET;
      page_r <= EDMP_PAGE_RESET;
      rdata_r <= 8'h00;
      hit_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      page_r <= page_nxt;
      rdata_r <= rdata_nxt;
      hit_r <= hit_nxt;
    end
  end

  // Field decode
  assign cfg = '{bank_hi: cfg_r[EDMP_BANK_BIT],
    separate: cfg_r[EDMP_MUX_BIT],
    map_mode: cfg_r[EDMP_MAP_LSB +: 2],
    ale_width: cfg_r[EDMP_ALE_LSB +: 2]};
  assign page_high_byte = page_r;
  assign sfr_rdata = rdata_r;
  assign sfr_hit = hit_r;
endmodule
`default_nettype wire

// ==== src/edmp_timer.sv ====
// Phase down-counter for the bus cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module edmp_timer (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [edmp_pkg::EDMP_CNT_W-1:0] cycles,
  output logic expired
);
  import edmp_pkg::*;

  logic [EDMP_CNT_W-1:0] cnt_r, cnt_nxt; // Cycles left in phase minus one

  // Load length minus one, then count to zero
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = cycles - 5'd1;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 5'd1;
    end
  end

  // Counter register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Last cycle of the current phase
  assign expired = (cnt_r == '0);
endmodule
`default_nettype wire

// ==== src/edmp_top.sv ====
// External data memory port: register block, address decode and bus cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module edmp_top (
  input wire logic core_clk,
  input wire logic resetn,
  // Special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // Strobe timing from bus_timing_control
  input wire edmp_pkg::edmp_timing_s timing,
  // Processor external move request
  input wire logic xmove_req,
  input wire logic xmove_write,
  input wire logic xmove_short,
  input wire logic [15:0] xmove_addr,
  input wire logic [7:0] xmove_wdata,
  output logic [7:0] xmove_rdata,
  output logic xmove_done,
  output logic xmove_stall,
  // On-chip data RAM
  output logic ram_req,
  output logic ram_we,
  output logic [edmp_pkg::EDMP_ONCHIP_AW-1:0] ram_addr,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] ram_rdata,
  // Port banks
  output edmp_pkg::edmp_pins_s pins_lo,
  output edmp_pkg::edmp_pins_s pins_hi,
  input wire logic [7:0] ad_in_lo,
  input wire logic [7:0] ad_in_hi,
  output logic claim_lo,
  output logic claim_hi
);
  import edmp_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ONCHIP, ST_ONWAIT, ST_ADDR, ST_ALE_HI, ST_ALE_LO, ST_SETUP, ST_STROBE, ST_HOLD, ST_TAIL
  } edmp_state_e;

  edmp_cfg_s cfg; // Live configuration
  logic [7:0] page_high_byte; // Live page select
  logic tmr_load; // Start a new phase
  logic [EDMP_CNT_W-1:0] tmr_cycles; // Length of the new phase
  logic tmr_exp; // Current phase ends this cycle

  edmp_state_e state_r, state_nxt; // Sequencer state
  edmp_cfg_s tcfg_r, tcfg_nxt; // Configuration snapshot per access
  edmp_timing_s ttim_r, ttim_nxt; // Timing snapshot per access
  logic [15:0] taddr_r, taddr_nxt; // Effective address
  logic twrite_r, twrite_nxt; // Access is a write
  logic thi_r, thi_nxt; // High address pins are driven
  logic [7:0] twdata_r, twdata_nxt; // Write data
  logic [7:0] rdata_r, rdata_nxt; // Returned read data
  logic done_r, done_nxt; // Completion pulse
  edmp_pins_s pins_r, pins_nxt; // Bus pin values
  logic claim_r, claim_nxt; // Pins owned by the interface
  logic [15:0] eff_addr; // Effective address of a new request
  logic offchip; // New request goes off-chip

  // Register block
  edmp_regs u_regs (
    .core_clk(core_clk),
    .resetn(resetn),
    .sfr_addr(sfr_addr),
    .sfr_we(sfr_we),
    .sfr_re(sfr_re),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit),
    .cfg(cfg),
    .page_high_byte(page_high_byte)
  );

  // Phase length counter
  edmp_timer u_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .load(tmr_load),
    .cycles(tmr_cycles),
    .expired(tmr_exp)
  );

  // Cycles of one latch strobe half
  function automatic logic [EDMP_CNT_W-1:0] ale_len(input logic [1:0] code);
    ale_len = {3'b000, code} + 5'd1;
  endfunction

  // Effective address: short moves take the high byte from the page register
  assign eff_addr = xmove_short ? {page_high_byte, xmove_addr[7:0]} : xmove_addr;

  // On-chip or off-chip by memory map mode
  always_comb begin
    case (cfg.map_mode)
      EDMP_MAP_INTERNAL: offchip = 1'b0;
      EDMP_MAP_SPLIT: offchip = (eff_addr >= EDMP_ONCHIP_TOP);
      EDMP_MAP_SPLIT_PAGE: offchip = (eff_addr >= EDMP_ONCHIP_TOP);
      default: offchip = 1'b1;
    endcase
  end

  // Sequencer next state, timer control and snapshots
  always_comb begin
    state_nxt = state_r;
    tcfg_nxt = tcfg_r;
    ttim_nxt = ttim_r;
    taddr_nxt = taddr_r;
    twrite_nxt = twrite_r;
    thi_nxt = thi_r;
    twdata_nxt = twdata_r;
    rdata_nxt = rdata_r;
    done_nxt = 1'b0;
    tmr_load = 1'b0;
    tmr_cycles = 5'd1;
    case (state_r)
      ST_IDLE: begin
        // A request still held after done is the old one
        if (xmove_req && !done_r) begin
          tcfg_nxt = cfg;
          ttim_nxt = timing;
          taddr_nxt = eff_addr;
          twrite_nxt = xmove_write;
          twdata_nxt = xmove_wdata;
          // Short moves drive A[15:8] only with page select mode
          thi_nxt = !xmove_short || cfg.map_mode == EDMP_MAP_SPLIT_PAGE;
          if (offchip) begin
            state_nxt = ST_ADDR;
            tmr_load = 1'b1;
            tmr_cycles = 5'(EDMP_ADDR_CYCLES);
          end else begin
            state_nxt = ST_ONCHIP;
          end
        end
      end
      ST_ONCHIP: begin
        state_nxt = ST_ONWAIT;
      end
      ST_ONWAIT: begin
        rdata_nxt = ram_rdata;
        done_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_ADDR: begin
        if (tmr_exp) begin
          tmr_load = 1'b1;
          if (!tcfg_r.separate) begin
            state_nxt = ST_ALE_HI;
            tmr_cycles = ale_len(tcfg_r.ale_width);
          end else if (ttim_r.setup != 2'b00) begin
            state_nxt = ST_SETUP;
            tmr_cycles = {3'b000, ttim_r.setup};
          end else begin
            state_nxt = ST_STROBE;
            tmr_cycles = {1'b0, ttim_r.width} + 5'd1;
          end
        end
      end
      ST_ALE_HI: begin
        if (tmr_exp) begin
          state_nxt = ST_ALE_LO;
          tmr_load = 1'b1;
          tmr_cycles = ale_len(tcfg_r.ale_width);
        end
      end
      ST_ALE_LO: begin
        if (tmr_exp) begin
          tmr_load = 1'b1;
          if (ttim_r.setup != 2'b00) begin
            state_nxt = ST_SETUP;
            tmr_cycles = {3'b000, ttim_r.setup};
          end else begin
            state_nxt = ST_STROBE;
            tmr_cycles = {1'b0, ttim_r.width} + 5'd1;
          end
        end
      end
      ST_SETUP: begin
        if (tmr_exp) begin
          state_nxt = ST_STROBE;
          tmr_load = 1'b1;
          tmr_cycles = {1'b0, ttim_r.width} + 5'd1;
        end
      end
      ST_STROBE: begin
        if (tmr_exp) begin
          // Sample the bus at the end of the strobe
          if (!twrite_r) begin
            rdata_nxt = tcfg_r.bank_hi ? ad_in_hi : ad_in_lo;
          end
          tmr_load = 1'b1;
          if (ttim_r.hold != 2'b00) begin
            state_nxt = ST_HOLD;
            tmr_cycles = {3'b000, ttim_r.hold};
          end else begin
            state_nxt = ST_TAIL;
            tmr_cycles = 5'(EDMP_TAIL_CYCLES);
          end
        end
      end
      ST_HOLD: begin
        if (tmr_exp) begin
          state_nxt = ST_TAIL;
          tmr_load = 1'b1;
          tmr_cycles = 5'(EDMP_TAIL_CYCLES);
        end
      end
      ST_TAIL: begin
        if (tmr_exp) begin
          state_nxt = ST_IDLE;
          done_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Pin values for the coming cycle
  always_comb begin
    pins_nxt = EDMP_PINS_IDLE;
    claim_nxt = 1'b0;
    case (state_nxt)
      ST_IDLE, ST_ONCHIP, ST_ONWAIT: begin
        claim_nxt = 1'b0;
      end
      default: begin
        claim_nxt = 1'b1;
        pins_nxt.addr_hi = taddr_nxt[15:8];
        pins_nxt.addr_hi_oe = thi_nxt;
        pins_nxt.strobe_oe = 1'b1;
        if (tcfg_nxt.separate) begin
          pins_nxt.addr_lo = taddr_nxt[7:0];
          pins_nxt.addr_lo_oe = 1'b1;
          pins_nxt.ad = twdata_nxt;
          pins_nxt.ad_oe = twrite_nxt;
        end else begin
          pins_nxt.ale_oe = 1'b1;
          pins_nxt.ale = (state_nxt == ST_ALE_HI);
          if (state_nxt == ST_ADDR || state_nxt == ST_ALE_HI || state_nxt == ST_ALE_LO) begin
            pins_nxt.ad = taddr_nxt[7:0];
            pins_nxt.ad_oe = 1'b1;
          end else begin
            pins_nxt.ad = twdata_nxt;
            pins_nxt.ad_oe = twrite_nxt;
          end
        end
        if (state_nxt == ST_STROBE) begin
          pins_nxt.rd_n = twrite_nxt;
          pins_nxt.wr_n = !twrite_nxt;
        end
      end
    endcase
  end

  // Sequencer and pin registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      tcfg_r <= '0;
      ttim_r <= '0;
      taddr_r <= 16'h0000;
      twrite_r <= 1'b0;
      thi_r <= 1'b0;
      twdata_r <= 8'h00;
      rdata_r <= 8'h00;
      done_r <= 1'b0;
      pins_r <= EDMP_PINS_IDLE;
      claim_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tcfg_r <= tcfg_nxt;
      ttim_r <= ttim_nxt;
      taddr_r <= taddr_nxt;
      twrite_r <= twrite_nxt;
      thi_r <= thi_nxt;
      twdata_r <= twdata_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
      pins_r <= pins_nxt;
      claim_r <= claim_nxt;
    end
  end

  // On-chip RAM access, address wraps on the 4k space
  assign ram_req = (state_r == ST_ONCHIP);
  assign ram_we = twrite_r;
  assign ram_addr = taddr_r[EDMP_ONCHIP_AW-1:0];
  assign ram_wdata = twdata_r;

  // Processor side; stall until the access completes
  assign xmove_stall = xmove_req && !done_r;
  assign xmove_done = done_r;
  assign xmove_rdata = rdata_r;

  // Bank routing; output mode of pins is not touched here
  assign pins_lo = (claim_r && !tcfg_r.bank_hi) ? pins_r : EDMP_PINS_IDLE;
  assign pins_hi = (claim_r && tcfg_r.bank_hi) ? pins_r : EDMP_PINS_IDLE;
  assign claim_lo = claim_r && !tcfg_r.bank_hi;
  assign claim_hi = claim_r && tcfg_r.bank_hi;
endmodule
`default_nettype wire

// ==== test/edmp_asserts.sv ====
// Checker of port behaviour for the external data memory port
`timescale 1ns/10ps
`default_nettype none
module edmp_asserts (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic xmove_req,
  input wire logic xmove_done,
  input wire logic xmove_stall,
  input wire logic ram_req,
  input wire edmp_pkg::edmp_pins_s pins_lo,
  input wire logic claim_lo,
  input wire logic claim_hi
);
  import edmp_pkg::*;
  // Single clock domain, reset gates every check
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Stall follows request until done
  property p_stall; xmove_stall == (xmove_req & ~xmove_done); endproperty
  a_stall: assert property (p_stall) else $error("stall not request minus done");
  // Done is a single pulse
  property p_done_pulse; xmove_done |=> !xmove_done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  // Never both banks at once
  property p_one_bank; !(claim_lo && claim_hi); endproperty
  a_one_bank: assert property (p_one_bank) else $error("both banks claimed");
  // Pins handed back exactly as the move ends
  property p_release; $fell(claim_lo) || $fell(claim_hi) |-> xmove_done; endproperty
  a_release: assert property (p_release) else $error("claim dropped without done");
  // Unclaimed lower bank leaves every driver off
  property p_idle_lo; !claim_lo |-> pins_lo == EDMP_PINS_IDLE; endproperty
  a_idle_lo: assert property (p_idle_lo) else $error("unclaimed bank not idle");
  // Data lines are inputs while reading
  property p_read_in; claim_lo && !pins_lo.rd_n |-> !pins_lo.ad_oe; endproperty
  a_read_in: assert property (p_read_in) else $error("data driver on during read");
  // Latch strobe high shows address, strobes idle
  property p_ale_addr; claim_lo && pins_lo.ale |-> pins_lo.ad_oe && pins_lo.rd_n && pins_lo.wr_n; endproperty
  a_ale_addr: assert property (p_ale_addr) else $error("latch phase without address");
  // On-chip access completes two cycles after the RAM request
  property p_ram_done; ram_req |-> ##2 xmove_done; endproperty
  a_ram_done: assert property (p_ram_done) else $error("on-chip done late");
  // On-chip access leaves the pins alone
  property p_ram_no_claim; ram_req |-> !claim_lo && !claim_hi; endproperty
  a_ram_no_claim: assert property (p_ram_no_claim) else $error("pins claimed on-chip");
  // Off-chip move owns the lower bank pins at least five cycles
  property p_min_len; $rose(claim_lo) |-> claim_lo [*5]; endproperty
  a_min_len: assert property (p_min_len) else $error("off-chip move too short");
endmodule
bind edmp_top edmp_asserts edmp_asserts_inst (.core_clk(core_clk), .resetn(resetn), .xmove_req(xmove_req),
  .xmove_done(xmove_done), .xmove_stall(xmove_stall), .ram_req(ram_req), .pins_lo(pins_lo),
  .claim_lo(claim_lo), .claim_hi(claim_hi));
`default_nettype wire

// ==== test/edmp_sram_model.sv ====
// Behavioural parallel memory on one port bank
`timescale 1ns/10ps
`default_nettype none
module edmp_sram_model #(
  parameter logic [7:0] PARK_HI = 8'hFF // Port latches parked high
) (
  input wire logic core_clk,
  input wire edmp_pkg::edmp_pins_s pins,
  output logic [7:0] ad_in
);
  import edmp_pkg::*;
  logic [7:0] mem [0:65535]; // Whole 16-bit space
  logic [7:0] lat_r; // External transparent address latch
  logic [7:0] last_r = 8'h00; // Last value shown on data lines
  logic [15:0] addr; // Address seen by the memory
  // Upper byte from pins or parked port latches
  assign addr = {pins.addr_hi_oe ? pins.addr_hi : PARK_HI,
    pins.addr_lo_oe ? pins.addr_lo : lat_r};
  // Read data only under read strobe, else a changing pattern
  assign ad_in = (pins.strobe_oe && !pins.rd_n) ? mem[addr] : ~last_r;
  // Latch follows shared lines, memory takes data under write strobe
  always @(posedge core_clk) begin
    if (pins.ale_oe && pins.ale) begin
      lat_r <= pins.ad;
    end
    if (pins.strobe_oe && !pins.wr_n && pins.ad_oe) begin
      mem[addr] <= pins.ad;
    end
    last_r <= ad_in;
  end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench of the external data memory port
`timescale 1ns/10ps
`default_nettype none
module tb;
  import edmp_pkg::*;
  logic core_clk, resetn, sfr_we, sfr_re, sfr_hit, xmove_req, xmove_write, xmove_short, xmove_done, xmove_stall;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xmove_wdata, xmove_rdata, ram_wdata, ram_rdata, ad_in_lo, ad_in_hi;
  logic [15:0] xmove_addr;
  logic ram_req, ram_we, claim_lo, claim_hi;
  logic [EDMP_ONCHIP_AW-1:0] ram_addr;
  edmp_timing_s timing;
  edmp_pins_s pins_lo, pins_hi;
  logic [7:0] ram [0:4095]; // On-chip data RAM
  logic [7:0] q; // Last read data
  int n_mismatch = 0;
  int compares = 0;
  int claim_cnt; // Cycles with a bank claimed
  logic saw_ram, saw_hi; // Seen during the last move
  edmp_top edmp_top_inst (.core_clk(core_clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_we(sfr_we),
    .sfr_re(sfr_re), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .timing(timing),
    .xmove_req(xmove_req), .xmove_write(xmove_write), .xmove_short(xmove_short), .xmove_addr(xmove_addr),
    .xmove_wdata(xmove_wdata), .xmove_rdata(xmove_rdata), .xmove_done(xmove_done), .xmove_stall(xmove_stall),
    .ram_req(ram_req), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
    .pins_lo(pins_lo), .pins_hi(pins_hi), .ad_in_lo(ad_in_lo), .ad_in_hi(ad_in_hi), .claim_lo(claim_lo),
    .claim_hi(claim_hi));
  edmp_sram_model sram_lo (.core_clk(core_clk), .pins(pins_lo), .ad_in(ad_in_lo));
  edmp_sram_model sram_hi (.core_clk(core_clk), .pins(pins_hi), .ad_in(ad_in_hi));
  // Clock, 20 ns period
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // One-cycle synchronous on-chip RAM
  always @(posedge core_clk) begin
    if (ram_req && ram_we) begin
      ram[ram_addr] <= ram_wdata;
    end
    ram_rdata <= ram[ram_addr];
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Register write, one-cycle strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_we <= 1'b1;
    @(posedge core_clk);
    sfr_we <= 1'b0;
  endtask
  // Register read, data and hit the cycle after
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_re <= 1'b1;
    @(posedge core_clk);
    sfr_re <= 1'b0;
    #1;
    chk({sfr_hit, sfr_rdata}, {(a == EDMP_CFG_ADDR) || (a == EDMP_PAGE_ADDR), exp});
  endtask
  // One move: request held until done, claims counted
  task automatic mv(input logic w, input logic s, input logic [15:0] a, input logic [7:0] d);
    int k;
    @(posedge core_clk);
    xmove_req <= 1'b1;
    xmove_write <= w;
    xmove_short <= s;
    xmove_addr <= a;
    xmove_wdata <= d;
    claim_cnt = 0;
    saw_ram = 1'b0;
    saw_hi = 1'b0;
    for (k = 0; k < 64; k++) begin
      @(posedge core_clk);
      #1;
      if (claim_lo || claim_hi) claim_cnt++;
      saw_ram |= ram_req;
      saw_hi |= claim_hi;
      if (xmove_done === 1'b1) break;
    end
    q = xmove_rdata;
    if (k == 64) begin
      n_mismatch++;
      close_out();
    end
    @(posedge core_clk);
    xmove_req <= 1'b0;
  endtask
  // Reset values, reserved bits, unmapped address
  task automatic t_regs();
    rd(EDMP_CFG_ADDR, EDMP_CFG_RESET);
    rd(EDMP_PAGE_ADDR, EDMP_PAGE_RESET);
    wr(EDMP_CFG_ADDR, 8'hFF);
    rd(EDMP_CFG_ADDR, 8'h3F);
    wr(EDMP_PAGE_ADDR, 8'hA5);
    rd(EDMP_PAGE_ADDR, 8'hA5);
    rd(8'hA4, 8'h00);
  endtask
  // Internal-only wrap and split-page boundary
  task automatic t_onchip();
    wr(EDMP_CFG_ADDR, 8'h10);
    mv(1'b1, 1'b0, 16'h2005, 8'h5A);
    chk({saw_ram, ram[12'h005]}, {1'b1, 8'h5A});
    mv(1'b0, 1'b0, 16'h1005, 8'h00);
    chk(q, 8'h5A);
    wr(EDMP_CFG_ADDR, 8'h18);
    mv(1'b1, 1'b0, 16'h0FFF, 8'h77);
    chk({saw_ram, ram[12'hFFF]}, {1'b1, 8'h77});
    mv(1'b1, 1'b0, 16'h1000, 8'h78);
    chk({saw_ram, claim_cnt[7:0], sram_lo.mem[16'h1000]}, {1'b0, 8'd5, 8'h78});
  endtask
  // Separate pins with programmed timing, external-only map
  task automatic t_sep();
    // Lower bank in use: crossbar skip taken as already set by software
    wr(EDMP_CFG_ADDR, 8'h1C);
    timing <= '{setup: 2'd1, width: 4'd2, hold: 2'd1};
    mv(1'b1, 1'b0, 16'h1234, 8'hA5);
    chk({claim_cnt[7:0], sram_lo.mem[16'h1234]}, {8'd9, 8'hA5});
    mv(1'b0, 1'b0, 16'h1234, 8'h00);
    chk({claim_cnt[7:0], q}, {8'd9, 8'hA5});
    timing <= '0;
    mv(1'b1, 1'b0, 16'h0010, 8'hC3);
    chk({saw_ram, sram_lo.mem[16'h0010]}, {1'b0, 8'hC3});
  endtask
  // Multiplexed pins, every latch pulse code
  task automatic t_mux();
    for (int k = 0; k < 4; k++) begin
      wr(EDMP_CFG_ADDR, 8'h0C | 8'(k));
      mv(1'b1, 1'b0, 16'h2300 + 16'(k), 8'h60 + 8'(k));
      chk(claim_cnt[15:0], 16'(7 + 2 * k));
      mv(1'b0, 1'b0, 16'h2300 + 16'(k), 8'h00);
      chk(q, 8'h60 + 8'(k));
    end
  endtask
  // Upper port bank
  task automatic t_bank();
    wr(EDMP_CFG_ADDR, 8'h3C);
    mv(1'b1, 1'b0, 16'h4444, 8'h3C);
    chk({saw_hi, sram_hi.mem[16'h4444]}, {1'b1, 8'h3C});
    mv(1'b0, 1'b0, 16'h4444, 8'h00);
    chk(q, 8'h3C);
  endtask
  // Short moves in split, split-page and external map modes
  task automatic t_short();
    wr(EDMP_PAGE_ADDR, 8'h56);
    wr(EDMP_CFG_ADDR, 8'h18);
    mv(1'b1, 1'b1, 16'hAB78, 8'h11);
    chk(sram_lo.mem[16'h5678], 8'h11);
    wr(EDMP_CFG_ADDR, 8'h14);
    mv(1'b1, 1'b1, 16'h0078, 8'h22);
    chk(sram_lo.mem[16'hFF78], 8'h22);
    wr(EDMP_CFG_ADDR, 8'h1C);
    mv(1'b1, 1'b1, 16'h0078, 8'h44);
    chk(sram_lo.mem[16'hFF78], 8'h44);
    wr(EDMP_PAGE_ADDR, 8'h00);
    wr(EDMP_CFG_ADDR, 8'h14);
    mv(1'b1, 1'b1, 16'h0078, 8'h33);
    chk({saw_ram, ram[12'h078]}, {1'b1, 8'h33});
  endtask
  // Main sequence
  initial begin
    resetn = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_we = 1'b0;
    sfr_re = 1'b0;
    timing = '0;
    xmove_req = 1'b0;
    xmove_write = 1'b0;
    xmove_short = 1'b0;
    xmove_addr = 16'h0000;
    xmove_wdata = 8'h00;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_onchip();
    t_sep();
    t_mux();
    t_bank();
    t_short();
    close_out();
  end
endmodule
`default_nettype wire
